// [rpms_pkg.sv]
// Package of constants, states and register carriers for the reset sequencer
package rpms_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ               = 50000000;
	localparam int SEQ_HALF_CLOCK_UNITS = 1024;
	localparam int SEQ_CYCLES           = SEQ_HALF_CLOCK_UNITS / 2;
	localparam int TRANS_CYCLES         = 4;
	localparam int CNT_W                = 10;
	localparam logic [CNT_W-1:0] SEQ_LAST   = 10'(SEQ_CYCLES - 1);
	localparam logic [CNT_W-1:0] TRANS_LAST = 10'(TRANS_CYCLES - 1);

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CFG    = 8'h00;
	localparam logic [7:0] ADDR_CMD    = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	// Configuration register fields
	localparam int CFG_BIDIR_BIT = 0;
	localparam int CFG_PWD_BIT   = 1;
	localparam int CFG_BOOT_BIT  = 2;

	// Command register fields, write-one pulses
	localparam int CMD_SWRST_BIT = 0;
	localparam int CMD_IDLE_BIT  = 1;
	localparam int CMD_POWERDOWN_INSTR_BIT = 2;
	localparam int CMD_FLAGC_BIT = 3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_HOLD,
		ST_TRANS,
		ST_SEQ,
		ST_PROLONG,
		ST_IDLE,
		ST_POWERDOWN_INSTR
	} rpms_state_e;

	typedef enum logic [1:0] {
		CAUSE_HW,
		CAUSE_SW,
		CAUSE_WDT
	} rpms_cause_e;

	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} rpms_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} rpms_axi_rsp_s;

endpackage

// [rpms_sequencer.sv]
// Reset and power mode sequencer with its AXI4-Lite register slave
`timescale 1ns/100ps

module rpms_sequencer
	import rpms_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire rpms_pkg::rpms_axi_req_s axi_req,
	output      rpms_pkg::rpms_axi_rsp_s axi_rsp,
	input  wire logic                 reset_input_pin,
	input  wire logic                 reset_mode_select_pin,
	input  wire logic                 nmi_pin,
	input  wire logic [7:0]           fast_ext_interrupt_pins,
	input  wire logic                 irq_request,
	input  wire logic                 irq_enabled,
	input  wire logic                 wdt_overflow,
	input  wire logic                 bus_active,
	input  wire logic                 bus_ready_used,
	input  wire logic                 bus_ready_pin,
	input  wire logic                 bus_waits_done,
	input  wire logic                 last_ready_seen,
	output      logic                 reset_output_pin,
	output      logic                 reset_pin_out,
	output      logic                 reset_pin_oe,
	output      logic                 io_float,
	output      logic                 internal_reset,
	output      logic                 hold_cancel,
	output      logic                 bus_abort,
	output      logic                 cpu_stop,
	output      logic                 periph_stop,
	output      logic                 osc_stop,
	output      logic                 isr_request
);
	import rpms_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		rpms_state_e      state;
		rpms_cause_e      cause;
		logic [CNT_W-1:0] cnt;
		logic             rst_sync1;
		logic             rst_sync2;
		logic             bidir_reset_enable;
		logic             powerdown_config_bit;
		logic             boot_mode;
		logic             wake_flag;
		logic             wdt_pending;
		logic             last_hw;
		logic             aw_got;
		logic             w_got;
		logic [7:0]       aw_addr;
		logic [31:0]      w_data;
		logic [3:0]       w_strb;
		rpms_axi_rsp_s    rsp;
		logic             reset_output_pin;
		logic             reset_pin_oe;
		logic             io_float;
		logic             internal_reset;
		logic             hold_cancel;
		logic             bus_abort;
		logic             cpu_stop;
		logic             periph_stop;
		logic             osc_stop;
		logic             isr_request;
	} rpms_regs_s;

	rpms_regs_s r;
	rpms_regs_s next_r;

	logic hw_req;
	logic async_hold;

	// Entry is caught straight from the pin so the I/O float and reset
	// output do not wait for a clock; release goes through the synchroniser.
	assign hw_req     = ~reset_input_pin & reset_mode_select_pin;
	assign async_hold = hw_req;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic       do_wr;
		logic [7:0] rd_addr;
		logic       sw_rst;
		logic       go_idle;
		logic       go_pd;
		logic       flag_clr;
		logic       wake;
		logic       bus_ok;
		next_r   = r;
		do_wr    = 1'b0;
		rd_addr  = axi_req.araddr;
		sw_rst   = 1'b0;
		go_idle  = 1'b0;
		go_pd    = 1'b0;
		flag_clr = 1'b0;
		wake     = |fast_ext_interrupt_pins;
		bus_ok   = ~bus_active & (~bus_ready_used | last_ready_seen);

		next_r.rst_sync1 = ~reset_input_pin;
		next_r.rst_sync2 = r.rst_sync1;
		next_r.hold_cancel = 1'b0;
		next_r.bus_abort   = 1'b0;

		// Bus slave: address and data may arrive in either order
		next_r.rsp.awready = 1'b0;
		next_r.rsp.wready  = 1'b0;
		next_r.rsp.arready = 1'b0;
		if (axi_req.awvalid && !r.aw_got && !r.rsp.bvalid)
		begin
			next_r.rsp.awready = ~r.rsp.awready;
			if (r.rsp.awready)
			begin
				next_r.aw_got  = 1'b1;
				next_r.aw_addr = axi_req.awaddr;
			end
		end
		if (axi_req.wvalid && !r.w_got && !r.rsp.bvalid)
		begin
			next_r.rsp.wready = ~r.rsp.wready;
			if (r.rsp.wready)
			begin
				next_r.w_got  = 1'b1;
				next_r.w_data = axi_req.wdata;
				next_r.w_strb = axi_req.wstrb;
			end
		end
		if (r.aw_got && r.w_got && !r.rsp.bvalid)
		begin
			do_wr            = 1'b1;
			next_r.aw_got    = 1'b0;
			next_r.w_got     = 1'b0;
			next_r.rsp.bvalid = 1'b1;
			next_r.rsp.bresp = (r.aw_addr == ADDR_CFG
				|| r.aw_addr == ADDR_CMD) ? RESP_OKAY : RESP_SLVERR;
		end
		if (r.rsp.bvalid && axi_req.bready)
			next_r.rsp.bvalid = 1'b0;

		if (do_wr && r.w_strb[0])
		begin
			if (r.aw_addr == ADDR_CFG)
			begin
				next_r.bidir_reset_enable   = r.w_data[CFG_BIDIR_BIT];
				next_r.powerdown_config_bit = r.w_data[CFG_PWD_BIT];
				next_r.boot_mode            = r.w_data[CFG_BOOT_BIT];
			end
			if (r.aw_addr == ADDR_CMD)
			begin
				sw_rst   = r.w_data[CMD_SWRST_BIT];
				go_idle  = r.w_data[CMD_IDLE_BIT];
				go_pd    = r.w_data[CMD_POWERDOWN_INSTR_BIT];
				flag_clr = r.w_data[CMD_FLAGC_BIT];
			end
		end

		if (axi_req.arvalid && !r.rsp.rvalid && !r.rsp.arready)
		begin
			next_r.rsp.arready = 1'b1;
			next_r.rsp.rvalid  = 1'b1;
			next_r.rsp.rresp   = RESP_OKAY;
			next_r.rsp.rdata   = '0;
			case (rd_addr)
				ADDR_CFG:
				begin
					next_r.rsp.rdata[CFG_BIDIR_BIT] = r.bidir_reset_enable;
					next_r.rsp.rdata[CFG_PWD_BIT]   = r.powerdown_config_bit;
					next_r.rsp.rdata[CFG_BOOT_BIT]  = r.boot_mode;
				end
				ADDR_CMD:
					next_r.rsp.rdata = '0;
				ADDR_STATUS:
					next_r.rsp.rdata = {15'h0000, r.wake_flag,
						r.last_hw, r.cause, r.state, r.cnt};
				default:
					next_r.rsp.rresp = RESP_SLVERR;
			endcase
		end
		else if (r.rsp.rvalid && axi_req.rready)
			next_r.rsp.rvalid = 1'b0;

		// Set wins over the software clear
		if (flag_clr)
			next_r.wake_flag = 1'b0;

		// A watchdog request waits for its bus cycle to settle
		if (wdt_overflow && !r.boot_mode && r.state != ST_HOLD
			&& r.state != ST_TRANS && r.state != ST_SEQ)
			next_r.wdt_pending = 1'b1;

		case (r.state)
			ST_RUN, ST_IDLE, ST_POWERDOWN_INSTR:
			begin
				if (r.wdt_pending)
				begin
					if (!bus_active || !bus_ready_used)
					begin
						next_r.wdt_pending = 1'b0;
						next_r.cause       = CAUSE_WDT;
						next_r.state       = ST_TRANS;
						next_r.cnt         = '0;
						next_r.hold_cancel = 1'b1;
					end
					else if (bus_waits_done)
					begin
						next_r.wdt_pending = 1'b0;
						next_r.cause       = CAUSE_WDT;
						next_r.state       = ST_TRANS;
						next_r.cnt         = '0;
						next_r.hold_cancel = 1'b1;
						next_r.bus_abort   = bus_ready_pin;
					end
				end
				else if (sw_rst)
				begin
					next_r.cause       = CAUSE_SW;
					next_r.state       = ST_TRANS;
					next_r.cnt         = '0;
					next_r.hold_cancel = 1'b1;
					next_r.bus_abort   = 1'b1;
				end
				else if (r.state == ST_IDLE)
				begin
					if (irq_request || wake)
					begin
						next_r.state    = ST_RUN;
						next_r.cpu_stop = 1'b0;
					end
				end
				else if (r.state == ST_POWERDOWN_INSTR)
				begin
					if (r.powerdown_config_bit && wake)
					begin
						next_r.state       = ST_RUN;
						next_r.cpu_stop    = 1'b0;
						next_r.periph_stop = 1'b0;
						next_r.osc_stop    = 1'b0;
						next_r.isr_request = irq_enabled;
						next_r.wake_flag   = 1'b1;
					end
				end
				else if (go_idle && bus_ok)
				begin
					next_r.state    = ST_IDLE;
					next_r.cpu_stop = 1'b1;
				end
				else if (go_pd && bus_ok
					&& (r.powerdown_config_bit || !nmi_pin))
				begin
					next_r.state       = ST_POWERDOWN_INSTR;
					next_r.cpu_stop    = 1'b1;
					next_r.periph_stop = 1'b1;
					next_r.osc_stop    = r.powerdown_config_bit;
				end
			end
			ST_HOLD:
				if (!r.rst_sync2)
				begin
					next_r.state       = ST_TRANS;
					next_r.cnt         = '0;
					next_r.hold_cancel = 1'b1;
					next_r.bus_abort   = 1'b1;
				end
			ST_TRANS:
			begin
				next_r.cnt = r.cnt + 10'h001;
				if (r.cnt == TRANS_LAST)
				begin
					next_r.state          = ST_SEQ;
					next_r.cnt            = '0;
					next_r.internal_reset = 1'b1;
					next_r.cpu_stop       = 1'b0;
					next_r.periph_stop    = 1'b0;
					next_r.osc_stop       = 1'b0;
					next_r.reset_pin_oe   = r.bidir_reset_enable
						|| r.cause == CAUSE_SW;
				end
			end
			ST_SEQ:
			begin
				next_r.cnt = r.cnt + 10'h001;
				if (r.cnt == SEQ_LAST)
				begin
					next_r.cnt                = '0;
					next_r.reset_pin_oe       = 1'b0;
					next_r.bidir_reset_enable = 1'b0;
					next_r.boot_mode          = 1'b0;
					next_r.powerdown_config_bit = 1'b0;
					next_r.state              = ST_PROLONG;
				end
			end
			ST_PROLONG:
				if (!r.rst_sync2)
				begin
					next_r.state            = ST_RUN;
					next_r.internal_reset   = 1'b0;
					next_r.reset_output_pin = 1'b0;
					next_r.io_float         = 1'b0;
				end
			default:
				next_r.state = ST_RUN;
		endcase

		// Reset output and float are set through the transition and sequence states, ahead of the internal reset
		if (r.state == ST_TRANS || r.state == ST_SEQ)
		begin
			next_r.reset_output_pin = 1'b1;
			next_r.io_float         = 1'b1;
		end

		// Mode pin gates entry only; the synced pin alone decides release
		if (r.rst_sync2 && reset_mode_select_pin
			&& r.state != ST_TRANS && r.state != ST_SEQ
			&& r.state != ST_PROLONG)
		begin
			next_r.state            = ST_HOLD;
			next_r.cause            = CAUSE_HW;
			next_r.last_hw          = 1'b1;
			next_r.reset_output_pin = 1'b1;
			next_r.io_float         = 1'b1;
			next_r.internal_reset   = 1'b1;
			next_r.reset_pin_oe     = 1'b0;
			next_r.wdt_pending      = 1'b0;
		end
		else if (r.state != ST_RUN && next_r.state == ST_TRANS)
			next_r.last_hw = r.last_hw;
		if (r.isr_request && !(r.state == ST_POWERDOWN_INSTR))
			next_r.isr_request = 1'b0;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			r       <= '0;
			r.state <= ST_RUN;
			r.cause <= CAUSE_HW;
		end
		else
		begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Reset output and float are also forced by the raw pin on entry;
	// the OR with a stored flag keeps them glitch-free once caught.
	always_comb
	begin
		axi_rsp          = r.rsp;
		reset_output_pin = r.reset_output_pin | async_hold;
		io_float         = r.io_float | async_hold;
		reset_pin_out    = 1'b0;
		reset_pin_oe     = r.reset_pin_oe;
		internal_reset   = r.internal_reset;
		hold_cancel      = r.hold_cancel;
		bus_abort        = r.bus_abort;
		cpu_stop         = r.cpu_stop;
		periph_stop      = r.periph_stop;
		osc_stop         = r.osc_stop;
		isr_request      = r.isr_request;
	end

endmodule

// [rpms_sequencer_properties.sv]
// Concurrent checks on the ports of the reset and power mode sequencer
`timescale 1ns/100ps
module rpms_sequencer_properties (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic reset_input_pin,
	input wire logic reset_mode_select_pin,
	input wire logic irq_request,
	input wire logic irq_enabled,
	input wire logic reset_output_pin,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe,
	input wire logic io_float,
	input wire logic internal_reset,
	input wire logic hold_cancel,
	input wire logic bus_abort,
	input wire logic cpu_stop,
	input wire logic periph_stop,
	input wire logic osc_stop,
	input wire logic isr_request
);
	// ----------------------------------------------------------------
	// Helper: length of the current pin drive
	// ----------------------------------------------------------------
	logic [10:0] oe_cnt;
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			oe_cnt <= '0;
		else
			oe_cnt <= reset_pin_oe ? oe_cnt + 11'h1 : 11'h0;
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_warm_entry;
		!reset_input_pin && reset_mode_select_pin |->
			reset_output_pin && io_float;
	endproperty
	a_warm_entry: assert property (p_warm_entry)
		else $error("warm reset entry not shown on outputs");
	property p_abort_pulse;
		hold_cancel |-> (bus_abort || !internal_reset) ##1 !hold_cancel;
	endproperty
	a_abort_pulse: assert property (p_abort_pulse)
		else $error("transition pulses wrong");
	property p_seq_len;
		$fell(reset_pin_oe) |-> oe_cnt == 11'd512;
	endproperty
	a_seq_len: assert property (p_seq_len)
		else $error("reset pin drive length is not 512 cycles");
	property p_oe_in_reset;
		reset_pin_oe |-> internal_reset && reset_output_pin;
	endproperty
	a_oe_in_reset: assert property (p_oe_in_reset)
		else $error("pin driven outside internal reset");
	property p_open_drain;
		reset_pin_out == 1'b0;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("reset pin driven high");
	property p_release_sync;
		$fell(internal_reset) |-> $past(reset_input_pin, 2);
	endproperty
	a_release_sync: assert property (p_release_sync)
		else $error("internal reset left with reset pin low");
	property p_idle_exit;
		cpu_stop && !periph_stop && irq_request |-> ##[1:3] !cpu_stop;
	endproperty
	a_idle_exit: assert property (p_idle_exit)
		else $error("idle not left on interrupt");
	property p_pd_stops;
		osc_stop |-> cpu_stop && periph_stop;
	endproperty
	a_pd_stops: assert property (p_pd_stops)
		else $error("oscillator stopped with cpu or peripherals on");
	property p_isr_pulse;
		isr_request |-> irq_enabled ##1 !isr_request;
	endproperty
	a_isr_pulse: assert property (p_isr_pulse)
		else $error("service request without enable or too long");
	cover property ($fell(reset_pin_oe));
	cover property ($fell(osc_stop));
	cover property (cpu_stop && !periph_stop);
endmodule

bind rpms_sequencer rpms_sequencer_properties rpms_sequencer_properties_inst (
	.clk_sys(clk_sys), .rst_n(rst_n), .reset_input_pin(reset_input_pin),
	.reset_mode_select_pin(reset_mode_select_pin),
	.irq_request(irq_request), .irq_enabled(irq_enabled),
	.reset_output_pin(reset_output_pin), .reset_pin_out(reset_pin_out),
	.reset_pin_oe(reset_pin_oe), .io_float(io_float),
	.internal_reset(internal_reset), .hold_cancel(hold_cancel),
	.bus_abort(bus_abort), .cpu_stop(cpu_stop), .periph_stop(periph_stop),
	.osc_stop(osc_stop), .isr_request(isr_request)
);

// [rpms_partner.sv]
// Board side model: reset line with pull-up, power-fail line, wake pins
`timescale 1ns/100ps
module rpms_partner (
	input  wire logic       hold_low,
	input  wire logic       pin_oe,
	input  wire logic       pin_out,
	input  wire logic       power_fail,
	input  wire logic [7:0] wake,
	output wire logic       reset_pin,
	output wire logic       nmi_pin,
	output wire logic [7:0] fast_pins
);
	// Pull-up wins only when neither party pulls the line
	assign reset_pin = (pin_oe ? pin_out : 1'b1) && !hold_low;
	assign nmi_pin = !power_fail;
	assign fast_pins = wake;
endmodule

// [rpms_sequencer_test.sv]
// Self-checking bench for the reset and power mode sequencer
`timescale 1ns/100ps
module rpms_sequencer_test;
	import rpms_pkg::*;
	logic          clk_sys, rst_n, mode, hold_low, power_fail, irq_req;
	logic          irq_en, wdt, bus_act, rdy_used, rdy_pin, waits, last_rdy;
	logic [7:0]    wake;
	rpms_axi_req_s rq;
	rpms_axi_rsp_s rs;
	wire           pin, nmi, pin_drv;
	wire  [7:0]    fast;
	wire  [9:0]    obs;
	int            mismatches, checks;
	rpms_sequencer rpms_sequencer_inst (
		.clk_sys(clk_sys), .rst_n(rst_n), .axi_req(rq), .axi_rsp(rs),
		.reset_input_pin(pin), .reset_mode_select_pin(mode),
		.nmi_pin(nmi), .fast_ext_interrupt_pins(fast),
		.irq_request(irq_req), .irq_enabled(irq_en), .wdt_overflow(wdt),
		.bus_active(bus_act), .bus_ready_used(rdy_used),
		.bus_ready_pin(rdy_pin), .bus_waits_done(waits),
		.last_ready_seen(last_rdy), .reset_output_pin(obs[8]),
		.reset_pin_out(pin_drv), .reset_pin_oe(obs[3]), .io_float(obs[9]),
		.internal_reset(obs[2]), .hold_cancel(obs[0]), .bus_abort(obs[1]),
		.cpu_stop(obs[4]), .periph_stop(obs[5]), .osc_stop(obs[6]),
		.isr_request(obs[7])
	);
	rpms_partner rpms_partner_inst (
		.hold_low(hold_low), .pin_oe(obs[3]), .pin_out(pin_drv),
		.power_fail(power_fail), .wake(wake), .reset_pin(pin),
		.nmi_pin(nmi), .fast_pins(fast)
	);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic limit(input bit ok);
		if (!ok)
		begin
			mismatches++;
			summarize;
		end
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Waits for output bit k to reach v; n counts the edges waited
	task automatic wait_v(input int k, input logic v, input int lim,
		output int n);
		for (n = 1; n <= lim; n++)
		begin
			@(posedge clk_sys);
			if (obs[k] === v)
				return;
		end
		limit(1'b0);
	endtask
	// One register access; for reads d is the expected value under mask m
	task automatic acc(input bit w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] m, input logic [1:0] er);
		int n;
		@(posedge clk_sys);
		rq.awaddr <= a;
		rq.araddr <= a;
		rq.wdata <= d;
		rq.wstrb <= 4'hf;
		{rq.awvalid, rq.wvalid, rq.bready} <= {3{w}};
		{rq.arvalid, rq.rready} <= {2{!w}};
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk_sys);
			if (rs.awready === 1'b1)
				rq.awvalid <= 1'b0;
			if (rs.wready === 1'b1)
				rq.wvalid <= 1'b0;
			if (rs.arready === 1'b1)
				rq.arvalid <= 1'b0;
			if ((w ? rs.bvalid : rs.rvalid) === 1'b1)
				break;
		end
		{rq.bready, rq.rready} <= 2'b00;
		limit(n < 50);
		cmp(32'(w ? rs.bresp : rs.rresp), 32'(er));
		if (!w)
			cmp(rs.rdata & m, d);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		acc(0, ADDR_CFG, 32'h0, 32'hffffffff, RESP_OKAY);
		acc(1, ADDR_CFG, 32'h7, 32'h0, RESP_OKAY);
		acc(0, ADDR_CFG, 32'h7, 32'h7, RESP_OKAY);
		acc(1, ADDR_STATUS, 32'h0, 32'h0, RESP_SLVERR);
		acc(0, 8'h0c, 32'h0, 32'h0, RESP_SLVERR);
		acc(0, ADDR_CMD, 32'h0, 32'hffffffff, RESP_OKAY);
		acc(1, ADDR_CFG, 32'h0, 32'h0, RESP_OKAY);
		$display("registers done");
	endtask
	// Mode pin low lets the pin be held low without a warm reset
	task automatic t_sw;
		int n;
		acc(1, ADDR_CFG, 32'h1, 32'h0, RESP_OKAY);
		mode <= 1'b0;
		// The cancel pulse lands while the write answer is being taken
		fork
			acc(1, ADDR_CMD, 32'h1, 32'h0, RESP_OKAY);
			wait_v(0, 1'b1, 10, n);
		join
		cmp(32'(obs[1]), 32'h1);
		hold_low <= 1'b1;
		wait_v(3, 1'b1, 10, n);
		wait_v(3, 1'b0, 600, n);
		cmp(n, 512);
		repeat (20) @(posedge clk_sys);
		cmp(32'(obs[2]), 32'h1);
		hold_low <= 1'b0;
		wait_v(2, 1'b0, 10, n);
		mode <= 1'b1;
		acc(0, ADDR_CFG, 32'h0, 32'h1, RESP_OKAY);
		$display("software reset done");
	endtask
	task automatic t_hw;
		int n;
		@(posedge clk_sys);
		hold_low <= 1'b1;
		#2 cmp(32'(obs[9:8]), 32'h3);
		repeat (5) @(posedge clk_sys);
		hold_low <= 1'b0;
		wait_v(0, 1'b1, 10, n);
		repeat (10) @(posedge clk_sys);
		cmp(32'(obs[3]), 32'h0);
		wait_v(2, 1'b0, 600, n);
		cmp(32'(n > 503 && n < 510), 32'h1);
		$display("hardware reset done");
	endtask
	task automatic t_wdt;
		int n;
		acc(1, ADDR_CFG, 32'h4, 32'h0, RESP_OKAY);
		wdt <= 1'b1;
		@(posedge clk_sys);
		wdt <= 1'b0;
		wait_v(0, 1'b0, 20, n);
		repeat (20) @(posedge clk_sys);
		cmp(32'(obs[2]), 32'h0);
		acc(1, ADDR_CFG, 32'h0, 32'h0, RESP_OKAY);
		{bus_act, rdy_used, rdy_pin, waits, wdt} <= 5'h1f;
		@(posedge clk_sys);
		wdt <= 1'b0;
		wait_v(1, 1'b1, 10, n);
		{bus_act, rdy_used, rdy_pin, waits} <= 4'h0;
		wait_v(2, 1'b1, 10, n);
		wait_v(2, 1'b0, 600, n);
		// A ready-less bus cycle is let finish, not aborted
		{bus_act, wdt} <= 2'b11;
		@(posedge clk_sys);
		wdt <= 1'b0;
		wait_v(0, 1'b1, 10, n);
		cmp(32'(obs[1]), 32'h0);
		bus_act <= 1'b0;
		wait_v(2, 1'b1, 10, n);
		wait_v(2, 1'b0, 600, n);
		$display("watchdog done");
	endtask
	task automatic pd_wake(input logic [7:0] w, input logic isr);
		int n;
		logic seen;
		seen = 1'b0;
		acc(1, ADDR_CMD, 32'h4, 32'h0, RESP_OKAY);
		wait_v(6, 1'b1, 10, n);
		cmp(32'(obs[5:4]), 32'h3);
		wake <= w;
		for (n = 0; n < 12; n++)
		begin
			@(posedge clk_sys);
			if (n == 2)
				wake <= 8'h00;
			seen = seen | obs[7];
		end
		cmp(32'(obs[6]), 32'h0);
		cmp(32'(seen), 32'(isr));
	endtask
	task automatic t_pwr;
		int n;
		rdy_used <= 1'b1;
		acc(1, ADDR_CMD, 32'h2, 32'h0, RESP_OKAY);
		repeat (4) @(posedge clk_sys);
		cmp(32'(obs[4]), 32'h0);
		rdy_used <= 1'b0;
		acc(1, ADDR_CMD, 32'h2, 32'h0, RESP_OKAY);
		wait_v(4, 1'b1, 10, n);
		cmp(32'(obs[5]), 32'h0);
		irq_req <= 1'b1;
		wait_v(4, 1'b0, 10, n);
		irq_req <= 1'b0;
		acc(1, ADDR_CMD, 32'h4, 32'h0, RESP_OKAY);
		repeat (4) @(posedge clk_sys);
		cmp(32'(obs[5]), 32'h0);
		acc(1, ADDR_CFG, 32'h2, 32'h0, RESP_OKAY);
		irq_en <= 1'b1;
		pd_wake(8'h01, 1'b1);
		irq_en <= 1'b0;
		pd_wake(8'h80, 1'b0);
		acc(0, ADDR_STATUS, 32'h10000, 32'h10000, RESP_OKAY);
		acc(1, ADDR_CMD, 32'h8, 32'h0, RESP_OKAY);
		acc(0, ADDR_STATUS, 32'h0, 32'h10000, RESP_OKAY);
		$display("power modes done");
	endtask
	// ----------------------------------------------------------------
	// Clock and main sequence
	// ----------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial
	begin
		{rst_n, mode, hold_low, power_fail, irq_req, irq_en} = 6'b010000;
		{wdt, bus_act, rdy_used, rdy_pin, waits, last_rdy} = 6'h00;
		wake = 8'h00;
		rq = '0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_regs;
		t_sw;
		t_hw;
		t_wdt;
		t_pwr;
		summarize;
	end
endmodule
